// file: rtl/ftcr_pkg.sv
// Purpose: shared constants for the fan and tachometer configuration bank
// Assumes: 8-bit register port, 100 MHz clock
// Notes: offsets are the byte addresses seen on the register port
package ftcr_pkg;

    // ---------------------------------------------------------------
    // register offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] OFF_GLOBAL_CONFIG = 8'h00;
    localparam logic [7:0] OFF_LOCK_CONFIG = 8'h01;
    localparam logic [7:0] OFF_FAN_CONTROL_CONFIG = 8'h02;
    localparam logic [7:0] OFF_MISC_FUNCTION_CONFIG = 8'h03;
    localparam logic [7:0] OFF_FAN_SPEED_INPUT_ENABLE = 8'h07;
    localparam logic [7:0] OFF_CONTINUOUS_MEAS_CONFIG = 8'h08;
    localparam logic [7:0] OFF_RESET_KEY = 8'h7b;

    // ---------------------------------------------------------------
    // values after reset and special values
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_FAN_CONTROL_CONFIG = 8'h80;
    localparam logic [7:0] RST_MISC_FUNCTION_CONFIG = 8'h00;
    localparam logic [7:0] RST_FAN_SPEED_INPUT_ENABLE = 8'h00;
    localparam logic [3:0] RST_CONTINUOUS_MEAS_CONFIG = 4'hf;
    localparam logic [7:0] RESET_KEY_VALUE = 8'h6d;
    localparam logic [7:0] FULL_DUTY = 8'hff;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int FAST_TACH_SAMPLING_BIT = 0;
    localparam int PWM_MODE_BIT = 2;
    localparam int VR1_IGNORE_BIT = 3;
    localparam int VR2_IGNORE_BIT = 4;
    localparam int FULL_SPEED_BIT = 5;
    localparam int TACH_PULSE_COUNT_LSB = 6;
    localparam int GPIO_EN_BIT = 0;
    localparam int SCL_TIMEOUT_BIT = 1;
    localparam int SDA_TIMEOUT_BIT = 2;
    localparam int VOLTAGE_ID_THRESHOLD_SEL_BIT = 3;
    localparam int THERMAL_INPUT_THRESHOLD_SEL_BIT = 4;
    localparam int INTRUSION_LATCH_CLEAR_BIT = 5;
    localparam int PARITY_CHAIN_TEST_EN_BIT = 6;
    localparam int CORE_RAIL_LOW_MODE_BIT = 7;
    localparam int SW_RESET_BIT = 7;
    localparam int LOCK_BIT = 6;
    localparam int READY_BIT = 7;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam longint unsigned CLK_HZ = 100_000_000;
    localparam longint unsigned MEAS_PERIOD_MS = 1000;
    localparam longint unsigned FAST_MEAS_PERIOD_MS = 250;
    localparam longint unsigned MEAS_PERIOD_CYCLES =
        MEAS_PERIOD_MS * CLK_HZ / 1000;
    localparam longint unsigned FAST_MEAS_PERIOD_CYCLES =
        FAST_MEAS_PERIOD_MS * CLK_HZ / 1000;
    localparam int TACH_COUNT_W = 32;

    typedef enum logic [1:0] {
        TACH_IDLE,
        TACH_WAIT_FIRST,
        TACH_WAIT_SECOND,
        TACH_COUNTING
    } ftcr_tach_state_t;

endpackage

// file: rtl/ftcr_regs.sv
// Purpose: fan and tachometer configuration registers with measurement
// Assumes: one 100 MHz clock, fan pins asynchronous to it
// Notes: pwm generation and the fan loop sit outside; they read the
//        controls driven here
//
// Summary of operation
// - low frequency mode measures once a second, four times if fast bit set
// - pwm mode bit: 0 low frequency pwm, 1 high frequency pwm
// - bit 3 clear lets vr_hot_input_1 force full fan speed
// - bit 4 clear lets vr_hot_input_2 force full fan speed
// - full-speed bit forces every fan to full speed
// - interval starts at second rising tach edge, ends x+1 pulses later
// - low frequency mode stretches pwm pulse unless pair is continuous
// - misc bit 0 enables general purpose io pins
// - misc bit 1 enables clock line timeout
// - misc bit 2 enables data line timeout
// - misc bit 3 picks low voltage-id input threshold
// - misc bit 4 picks low thermal input threshold
// - intrusion clear bit resets the intrusion latch and self-clears
// - misc bits 6 and 7 enable chain test and low core rail
// - input enable bits 0 to 7 enable fan speed inputs 1 to 8
// - continuous bits 0 to 3 cover pairs 1/5, 2/6, 3/7, 4/8
// - continuous pair gets no stretch and no pwm synchronisation
// - continuous register bits 7:4 reserved and read only
// - misc and enable registers reset to zero, lockable, soft resettable
// - once lock set, lockable registers are read only until power cycle
// - soft reset restores unlocked registers after key 0x6d at 0x7b
`timescale 1ns/1ps

module ftcr_regs #(
    parameter longint unsigned MEAS_PERIOD = ftcr_pkg::MEAS_PERIOD_CYCLES,
    parameter longint unsigned FAST_PERIOD =
        ftcr_pkg::FAST_MEAS_PERIOD_CYCLES
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic vr_hot_input_1,
    input wire logic vr_hot_input_2,
    input wire logic [7:0] fan_speed_input,
    input wire logic [7:0] loop_duty,
    output logic [7:0] fan_duty,
    output logic fan_full_speed,
    output logic pwm_high_freq,
    output logic [3:0] pwm_stretch,
    output logic [3:0] pwm_tach_sync,
    output logic [7:0] tach_valid,
    output logic [ftcr_pkg::TACH_COUNT_W-1:0] tach_count [8],
    output logic gpio_enable,
    output logic scl_timeout_en,
    output logic sda_timeout_en,
    output logic voltage_id_threshold_sel,
    output logic thermal_input_threshold_sel,
    output logic intrusion_latch_clear,
    output logic parity_chain_test_en,
    output logic core_rail_low_mode,
    output logic regs_locked
);

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] fan_control_config;
    logic [7:0] misc_function_config;
    logic [7:0] fan_speed_input_enable;
    logic [3:0] continuous_meas_config;
    logic lock;
    logic key_armed;

    wire hit_global = reg_addr == ftcr_pkg::OFF_GLOBAL_CONFIG;
    wire hit_lock = reg_addr == ftcr_pkg::OFF_LOCK_CONFIG;
    wire hit_fan = reg_addr == ftcr_pkg::OFF_FAN_CONTROL_CONFIG;
    wire hit_misc = reg_addr == ftcr_pkg::OFF_MISC_FUNCTION_CONFIG;
    wire hit_en = reg_addr == ftcr_pkg::OFF_FAN_SPEED_INPUT_ENABLE;
    wire hit_cont = reg_addr == ftcr_pkg::OFF_CONTINUOUS_MEAS_CONFIG;
    wire hit_key = reg_addr == ftcr_pkg::OFF_RESET_KEY;

    // writes to lockable registers are dropped once locked
    wire wr_ok = reg_wr && !lock;
    wire soft_reset = reg_wr && hit_global && key_armed
        && reg_wdata[ftcr_pkg::SW_RESET_BIT];
    // a locked register also ignores the soft reset
    wire clr_ok = soft_reset && !lock;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fan_control_config <= ftcr_pkg::RST_FAN_CONTROL_CONFIG;
            misc_function_config <= ftcr_pkg::RST_MISC_FUNCTION_CONFIG;
            fan_speed_input_enable <= ftcr_pkg::RST_FAN_SPEED_INPUT_ENABLE;
            continuous_meas_config <= ftcr_pkg::RST_CONTINUOUS_MEAS_CONFIG;
        end
        else if (clr_ok)
        begin
            fan_control_config <= ftcr_pkg::RST_FAN_CONTROL_CONFIG;
            misc_function_config <= ftcr_pkg::RST_MISC_FUNCTION_CONFIG;
            fan_speed_input_enable <= ftcr_pkg::RST_FAN_SPEED_INPUT_ENABLE;
            continuous_meas_config <= ftcr_pkg::RST_CONTINUOUS_MEAS_CONFIG;
        end
        else
        begin
            if (wr_ok && hit_fan)
                fan_control_config <= reg_wdata;
            if (wr_ok && hit_misc)
                misc_function_config <= reg_wdata;
            else
                misc_function_config[ftcr_pkg::INTRUSION_LATCH_CLEAR_BIT]
                    <= 1'b0;
            if (wr_ok && hit_en)
                fan_speed_input_enable <= reg_wdata;
            if (wr_ok && hit_cont)
                continuous_meas_config <= reg_wdata[3:0];
        end
    end

    // lock is write once and only a power-on reset clears it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            lock <= 1'b0;
        else if (reg_wr && hit_lock && reg_wdata[ftcr_pkg::LOCK_BIT])
            lock <= 1'b1;
    end

    // key must be the last write to 0x7b, with no global write since, before the reset bit is set
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            key_armed <= 1'b0;
        else if (reg_wr && hit_key)
            key_armed <= reg_wdata == ftcr_pkg::RESET_KEY_VALUE;
        else if (reg_wr && hit_global)
            key_armed <= 1'b0;
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    wire [7:0] lock_view = {1'b1, lock, 6'h00};

    wire [7:0] rd_mux = hit_fan ? fan_control_config
        : hit_misc ? misc_function_config
        : hit_en ? fan_speed_input_enable
        : hit_cont ? {4'h0, continuous_meas_config}
        : hit_lock ? lock_view
        : 8'h00;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rd_mux;
    end

    // ---------------------------------------------------------------
    // static controls
    // ---------------------------------------------------------------
    assign gpio_enable =
        misc_function_config[ftcr_pkg::GPIO_EN_BIT];
    assign scl_timeout_en =
        misc_function_config[ftcr_pkg::SCL_TIMEOUT_BIT];
    assign sda_timeout_en =
        misc_function_config[ftcr_pkg::SDA_TIMEOUT_BIT];
    assign voltage_id_threshold_sel =
        misc_function_config[ftcr_pkg::VOLTAGE_ID_THRESHOLD_SEL_BIT];
    assign thermal_input_threshold_sel =
        misc_function_config[ftcr_pkg::THERMAL_INPUT_THRESHOLD_SEL_BIT];
    assign intrusion_latch_clear =
        misc_function_config[ftcr_pkg::INTRUSION_LATCH_CLEAR_BIT];
    assign parity_chain_test_en =
        misc_function_config[ftcr_pkg::PARITY_CHAIN_TEST_EN_BIT];
    assign core_rail_low_mode =
        misc_function_config[ftcr_pkg::CORE_RAIL_LOW_MODE_BIT];
    assign pwm_high_freq =
        fan_control_config[ftcr_pkg::PWM_MODE_BIT];
    assign regs_locked = lock;

    // ---------------------------------------------------------------
    // full-speed override
    // ---------------------------------------------------------------
    logic [1:0] vr_meta;
    logic [1:0] vr_sync;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            vr_meta <= 2'h0;
            vr_sync <= 2'h0;
        end
        else
        begin
            vr_meta <= {vr_hot_input_2, vr_hot_input_1};
            vr_sync <= vr_meta;
        end
    end

    wire vr1_boost = vr_sync[0]
        && !fan_control_config[ftcr_pkg::VR1_IGNORE_BIT];
    wire vr2_boost = vr_sync[1]
        && !fan_control_config[ftcr_pkg::VR2_IGNORE_BIT];
    wire next_full = fan_control_config[ftcr_pkg::FULL_SPEED_BIT]
        || vr1_boost || vr2_boost;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fan_full_speed <= 1'b0;
            fan_duty <= 8'h00;
        end
        else
        begin
            fan_full_speed <= next_full;
            fan_duty <= next_full ? ftcr_pkg::FULL_DUTY
                : loop_duty;
        end
    end

    // ---------------------------------------------------------------
    // measurement rate
    // ---------------------------------------------------------------
    // the fast rate only applies in low frequency mode
    wire fast_sel = fan_control_config[ftcr_pkg::FAST_TACH_SAMPLING_BIT]
        && !pwm_high_freq;
    wire [31:0] period_m1 = fast_sel ? 32'(FAST_PERIOD - 1)
        : 32'(MEAS_PERIOD - 1);
    logic [31:0] rate_cnt;
    wire meas_tick = rate_cnt >= period_m1;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rate_cnt <= 32'h0;
        else
            rate_cnt <= meas_tick ? 32'h0 : rate_cnt + 32'h1;
    end

    // ---------------------------------------------------------------
    // tachometer channels
    // ---------------------------------------------------------------
    logic [7:0] tach_meta;
    logic [7:0] tach_sync;
    logic [7:0] tach_prev;
    logic [7:0] busy;
    wire [7:0] tach_rise = tach_sync & ~tach_prev;
    wire [2:0] pulses_m1 = {1'b0,
        fan_control_config[ftcr_pkg::TACH_PULSE_COUNT_LSB +: 2]};

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tach_meta <= 8'h00;
            tach_sync <= 8'h00;
            tach_prev <= 8'h00;
        end
        else
        begin
            tach_meta <= fan_speed_input;
            tach_sync <= tach_meta;
            tach_prev <= tach_sync;
        end
    end

    generate
        for (genvar ch = 0; ch < 8; ch++)
        begin : g_tach
            ftcr_pkg::ftcr_tach_state_t st;
            logic [2:0] left;
            logic [ftcr_pkg::TACH_COUNT_W-1:0] cyc;
            wire en = fan_speed_input_enable[ch];
            wire sat = &cyc;
            assign busy[ch] = st != ftcr_pkg::TACH_IDLE;
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    st <= ftcr_pkg::TACH_IDLE;
                    left <= 3'h0;
                    cyc <= '0;
                    tach_count[ch] <= '0;
                    tach_valid[ch] <= 1'b0;
                end
                else
                begin
                    tach_valid[ch] <= 1'b0;
                    case (st)
                        ftcr_pkg::TACH_IDLE:
                            if (en && meas_tick)
                                st <= ftcr_pkg::TACH_WAIT_FIRST;
                        ftcr_pkg::TACH_WAIT_FIRST:
                            if (tach_rise[ch])
                                st <= ftcr_pkg::TACH_WAIT_SECOND;
                        ftcr_pkg::TACH_WAIT_SECOND:
                            if (tach_rise[ch])
                            begin
                                st <= ftcr_pkg::TACH_COUNTING;
                                left <= pulses_m1;
                                cyc <= '0;
                            end
                        ftcr_pkg::TACH_COUNTING:
                        begin
                            if (!sat)
                                cyc <= cyc + 1'b1;
                            if (tach_rise[ch])
                            begin
                                if (left == 3'h0)
                                begin
                                    st <= ftcr_pkg::TACH_IDLE;
                                    tach_count[ch] <= cyc + 1'b1;
                                    tach_valid[ch] <= 1'b1;
                                end
                                else
                                    left <= left - 3'h1;
                            end
                        end
                        default:
                            st <= ftcr_pkg::TACH_IDLE;
                    endcase
                    // stalled fan: no edges before the next tick
                    if (busy[ch] && (meas_tick || !en))
                    begin
                        st <= ftcr_pkg::TACH_IDLE;
                        tach_count[ch] <= '1;
                        tach_valid[ch] <= en;
                    end
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // pulse stretch and synchronisation per pair
    // ---------------------------------------------------------------
    logic [3:0] next_stretch;
    for (genvar pr = 0; pr < 4; pr++)
    begin : g_pair
        // continuous pairs neither stretch nor sync to the pwm
        assign next_stretch[pr] = !pwm_high_freq
            && !continuous_meas_config[pr]
            && (busy[pr] || busy[pr + 4]);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwm_stretch <= 4'h0;
            pwm_tach_sync <= 4'h0;
        end
        else
        begin
            pwm_stretch <= next_stretch;
            pwm_tach_sync <= pwm_high_freq ? 4'h0
                : ~continuous_meas_config;
        end
    end

endmodule

// file: dv/ftcr_regs_assertions.sv
// Purpose: port-level checks for the fan and continuous_meas_config bank
// Assumes: one clock domain, nrst asynchronous and active low
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ps
module ftcr_regs_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic vr_hot_input_1,
    input wire logic vr_hot_input_2,
    input wire logic [7:0] loop_duty,
    input wire logic [7:0] fan_duty,
    input wire logic fan_full_speed,
    input wire logic pwm_high_freq,
    input wire logic [3:0] pwm_stretch,
    input wire logic [3:0] pwm_tach_sync,
    input wire logic intrusion_latch_clear,
    input wire logic regs_locked
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic [5:0] cause_q;
    wire cause_now = vr_hot_input_1 | vr_hot_input_2 |
        (reg_wr & (reg_addr == 8'h02) & reg_wdata[5]);
    wire clr_wr = reg_wr & (reg_addr == 8'h03) & reg_wdata[5];

    // six cycles of history covers the pin synchroniser lag
    always_ff @(posedge clk or negedge nrst)
        if (!nrst)
            cause_q <= 6'h00;
        else
            cause_q <= {cause_q[4:0], cause_now};

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_full_duty;
        fan_full_speed && $past(fan_full_speed) |-> fan_duty == 8'hff;
    endproperty
    a_full_duty: assert property (p_full_duty)
        else $error("duty not full while full speed");
    property p_loop_duty;
        $past(nrst) && !fan_full_speed && !$past(fan_full_speed) |->
            fan_duty == $past(loop_duty);
    endproperty
    a_loop_duty: assert property (p_loop_duty)
        else $error("duty does not follow loop");
    property p_full_cause;
        $rose(fan_full_speed) |-> cause_q != 6'h00;
    endproperty
    a_full_cause: assert property (p_full_cause)
        else $error("full speed without a cause");
    property p_clr_pulse;
        intrusion_latch_clear && !clr_wr |=> !intrusion_latch_clear;
    endproperty
    a_clr_pulse: assert property (p_clr_pulse)
        else $error("intrusion clear did not self clear");
    property p_clr_cause;
        $rose(intrusion_latch_clear) |-> $past(clr_wr && !regs_locked);
    endproperty
    a_clr_cause: assert property (p_clr_cause)
        else $error("intrusion clear without unlocked write");
    property p_lock_freeze;
        regs_locked && reg_wr && reg_addr == 8'h02 |=> $stable(pwm_high_freq);
    endproperty
    a_lock_freeze: assert property (p_lock_freeze)
        else $error("locked register changed");
    property p_hf_quiet;
        pwm_high_freq && $past(pwm_high_freq) |->
            pwm_stretch == 4'h0 && pwm_tach_sync == 4'h0;
    endproperty
    a_hf_quiet: assert property (p_hf_quiet)
        else $error("stretch or sync in high frequency mode");
    property p_stretch_sync;
        (pwm_stretch & ~pwm_tach_sync) == 4'h0;
    endproperty
    a_stretch_sync: assert property (p_stretch_sync)
        else $error("stretch on a continuous pair");

    c_full: cover property ($rose(fan_full_speed));
    c_stretch: cover property (pwm_stretch != 4'h0);
    c_locked_wr: cover property (regs_locked && reg_wr);
endmodule

bind ftcr_regs ftcr_regs_chk chk_u (
    .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .vr_hot_input_1,
    .vr_hot_input_2, .loop_duty, .fan_duty, .fan_full_speed,
    .pwm_high_freq, .pwm_stretch, .pwm_tach_sync,
    .intrusion_latch_clear, .regs_locked
);

// file: dv/ftcr_fan_model.sv
// Purpose: tach output of one free-running cooling fan
// Assumes: fixed speed, open-collector output with pull-up
// Notes: 3 ns offset keeps tach edges away from bench clock edges
`timescale 1ns/1ps
module ftcr_fan_model #(
    parameter int HALF_NS = 50
)
(
    output logic tach
);
    // ----------------------------------------------------------------
    // pulse train
    // ----------------------------------------------------------------
    initial
    begin
        tach = 1'b1;
        #3;
        forever
            #HALF_NS tach = ~tach;
    end
endmodule

// file: dv/tb.sv
// Purpose: directed bench for the fan and continuous_meas_config bank
// Assumes: 100 MHz clock, shortened measurement periods
// Notes: fan i gives a tach period of 10+2i clock cycles
`timescale 1ns/1ps
module tb;
    localparam int MP = 400;
    logic clk, nrst, reg_wr, reg_rd, fan_full_speed, pwm_high_freq;
    logic regs_locked;
    logic [1:0] vr;
    logic [3:0] pwm_stretch, pwm_tach_sync;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, loop_duty, fan_duty;
    logic [7:0] fan_speed_input, tach_valid, misc_o;
    logic [ftcr_pkg::TACH_COUNT_W-1:0] tach_count [8];
    int mismatches, tests_run;

    // ----------------------------------------------------------------
    // design and fans
    // ----------------------------------------------------------------
    ftcr_regs #(.MEAS_PERIOD(MP), .FAST_PERIOD(MP / 4)) dut_u (
        .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .vr_hot_input_1(vr[0]), .vr_hot_input_2(vr[1]), .fan_speed_input,
        .loop_duty, .fan_duty, .fan_full_speed, .pwm_high_freq,
        .pwm_stretch, .pwm_tach_sync, .tach_valid, .tach_count,
        .gpio_enable(misc_o[0]), .scl_timeout_en(misc_o[1]),
        .sda_timeout_en(misc_o[2]), .voltage_id_threshold_sel(misc_o[3]),
        .thermal_input_threshold_sel(misc_o[4]),
        .intrusion_latch_clear(misc_o[5]),
        .parity_chain_test_en(misc_o[6]), .core_rail_low_mode(misc_o[7]),
        .regs_locked
    );
    for (genvar i = 0; i < 8; i++)
    begin : g_fan
        ftcr_fan_model #(.HALF_NS(50 + 10 * i)) fan_u (
            .tach(fan_speed_input[i])
        );
    end

    initial
    begin
        clk = 1'b0;
        forever
            #5 clk = ~clk;
    end

    // about 9000 cycles expected; 20000 cycles means a hang
    initial
    begin
        #200000;
        mismatches++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, want);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic defaults();
        rd_chk(8'h02, 8'h80);
        rd_chk(8'h03, 8'h00);
        rd_chk(8'h07, 8'h00);
        rd_chk(8'h08, 8'h0f);
    endtask
    // three periods so the last result started after the write
    task automatic meas(input logic [1:0] x);
        logic [31:0] last [8];
        wr(8'h02, {x, 6'h00});
        repeat (3 * MP)
        begin
            @(posedge clk);
            #1;
            for (int i = 0; i < 8; i++)
                if (tach_valid[i] === 1'b1)
                    last[i] = tach_count[i];
            if (tach_valid[1] === 1'b1)
                chk(pwm_stretch & 4'h3, 4'h2);
        end
        for (int i = 0; i < 8; i++)
            chk(last[i], (x + 1) * (10 + 2 * i));
    endtask
    // window phase against the rate tick allows one result either way
    task automatic rate(input logic [7:0] cfg, input int lo, input int hi);
        int n;
        n = 0;
        wr(8'h02, cfg);
        tick(MP);
        repeat (2 * MP)
        begin
            @(posedge clk);
            #1;
            n += (tach_valid[0] === 1'b1);
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        vr = 2'b00;
        loop_duty = 8'h40;
        mismatches = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        defaults();
        rd_chk(8'h01, 8'h80);
        rd_chk(8'h05, 8'h00);
        for (int b = 0; b < 8; b++)
        begin
            wr(8'h03, 8'h01 << b);
            #1;
            chk(misc_o, 8'h01 << b);
            rd_chk(8'h03, (b == 5) ? 8'h00 : 8'h01 << b);
        end
        wr(8'h08, 8'hff);
        rd_chk(8'h08, 8'h0f);
        wr(8'h07, 8'ha5);
        rd_chk(8'h07, 8'ha5);
        wr(8'h02, 8'ha0);
        tick(3);
        chk({fan_full_speed, fan_duty}, 9'h1ff);
        for (int j = 0; j < 2; j++)
        begin
            wr(8'h02, 8'h80);
            @(posedge clk) vr[j] <= 1'b1;
            tick(6);
            chk({fan_full_speed, fan_duty}, 9'h1ff);
            wr(8'h02, 8'h80 | (8'h08 << j));
            tick(3);
            chk({fan_full_speed, fan_duty}, 9'h040);
            @(posedge clk) vr[j] <= 1'b0;
        end
        wr(8'h08, 8'h05);
        tick(2);
        chk(pwm_tach_sync, 4'ha);
        wr(8'h02, 8'h84);
        tick(2);
        chk({pwm_high_freq, pwm_stretch, pwm_tach_sync}, 9'h100);
        wr(8'h07, 8'hff);
        for (int x = 0; x < 4; x++)
            meas(x[1:0]);
        rate(8'h01, 7, 9);
        rate(8'h00, 1, 3);
        rate(8'h05, 1, 3);
        wr(8'h07, 8'h5a);
        wr(8'h00, 8'h80);
        rd_chk(8'h07, 8'h5a);
        wr(8'h7b, 8'h6d);
        wr(8'h00, 8'h80);
        defaults();
        wr(8'h03, 8'h06);
        wr(8'h01, 8'h40);
        wr(8'h03, 8'h20);
        wr(8'h07, 8'h11);
        wr(8'h02, 8'h04);
        tick(1);
        chk(pwm_high_freq, 1'b0);
        chk(regs_locked, 1'b1);
        wr(8'h01, 8'h00);
        wr(8'h7b, 8'h6d);
        wr(8'h00, 8'h80);
        rd_chk(8'h01, 8'hc0);
        rd_chk(8'h03, 8'h06);
        rd_chk(8'h07, 8'h00);
        @(posedge clk) nrst <= 1'b0;
        tick(3);
        @(posedge clk) nrst <= 1'b1;
        defaults();
        rd_chk(8'h01, 8'h80);
        end_sim();
    end
endmodule
